// [rtl/lsip_pkg.sv]
package lsip_pkg;

    // one 8-bit pin group as seen from the pad
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } lsip_drive_t;

    // read answer held for the bus
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } lsip_rd_t;

endpackage : lsip_pkg

// [rtl/lsip_regs.svh]
// Operation
// - group one is 8 bits; pins 0-4 are bidirectional digital or segment
// - group one pins 5-7 are digital input, segment or common; never digital out
// - group one direction steers pins 0-4 only, and only in digital mode
// - segment-enable bits reset to one, so shared pins start as LCD outputs
// - a set segment-enable bit hands its pins to the LCD driver regardless of direction
// - group two is input-only when digital; each pin shares one segment
// - group three is input-only when digital; each pin shares one segment
// - group four is input-only when digital; each pin shares one segment
// - group one bits 0-4 carry segments 0-4 in order
// - group one bits 5,6,7 carry segment 29/30/31 or common 3/2/1
// - group two bits 0-6 carry segments 5-11 in order
// - group two bit 7 carries segment 27, larger package only
// - group three bits 0-7 carry segments 12-19 in order
// - group four bits 0-6 carry segments 20-26, bit 7 segment 28 large package
// - data register read returns pin levels; a group one write loads the output latch
`ifndef LSIP_REGS_SVH
`define LSIP_REGS_SVH

// register indices; byte address is four times the index
`define LSIP_IDX_G1_DATA 10'h008
`define LSIP_IDX_G2_DATA 10'h009
`define LSIP_IDX_G1_DIR 10'h088
`define LSIP_IDX_G2_DIR 10'h089
`define LSIP_IDX_G3_DATA 10'h107
`define LSIP_IDX_G4_DATA 10'h108
`define LSIP_IDX_SEG_EN 10'h10d
`define LSIP_IDX_G3_DIR 10'h187
`define LSIP_IDX_G4_DIR 10'h188

// reset values
`define LSIP_RST_LATCH 8'h00
`define LSIP_RST_DIR 8'hff
`define LSIP_RST_SEG_EN 8'hff

// segment-enable field positions
`define LSIP_SE_G1_LO 0
`define LSIP_SE_B 1
`define LSIP_SE_C 2
`define LSIP_SE_D 3
`define LSIP_SE_E 4
`define LSIP_SE_F 5
`define LSIP_SE_G 6
`define LSIP_SE_G1_HI 7

// bus answers
`define LSIP_RESP_OKAY 2'b00
`define LSIP_RESP_SLVERR 2'b10

`endif

// [rtl/lsip_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lsip_regs.svh"

module lsip_top
    import lsip_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // lcd driver sources
    input wire logic [31:0] lcd_seg_in,
    input wire logic [3:1] lcd_com_in,
    input wire logic [2:0] lcd_com_sel_in,
    // pads of the four groups
    input wire logic [7:0] g1_pin_in,
    output logic [7:0] g1_pin_out,
    output logic [7:0] g1_pin_oe_out,
    input wire logic [7:0] g2_pin_in,
    output logic [7:0] g2_pin_out,
    output logic [7:0] g2_pin_oe_out,
    input wire logic [7:0] g3_pin_in,
    output logic [7:0] g3_pin_out,
    output logic [7:0] g3_pin_oe_out,
    input wire logic [7:0] g4_pin_in,
    output logic [7:0] g4_pin_out,
    output logic [7:0] g4_pin_oe_out
);

////////////////////////////////////////////////////////////////////////////////
// registers

logic [7:0] group_one_pin_data;
logic [7:0] group_one_direction;
logic [7:0] group_two_direction;
logic [7:0] group_three_direction;
logic [7:0] group_four_direction;
logic [7:0] segment_enable_select;
logic [31:0] pin_meta;
logic [31:0] pin_sync;
logic [9:0] aw_idx;
logic aw_full;
logic [7:0] w_byte;
logic w_lane;
logic w_full;
logic [1:0] bresp;
logic bvalid;
lsip_rd_t rd_hold;
logic rvalid;
lsip_drive_t next_g1;
lsip_drive_t next_g2;
lsip_drive_t next_g3;
lsip_drive_t next_g4;
lsip_drive_t g1_drv;
lsip_drive_t g2_drv;
lsip_drive_t g3_drv;
lsip_drive_t g4_drv;
logic [7:0] g1_lcd_own;
logic [7:0] g2_lcd_own;
logic [7:0] g3_lcd_own;
logic [7:0] g4_lcd_own;
logic [7:0] g1_lcd_val;
logic [7:0] large_mask;
logic wr_fire;
logic wr_hit;
logic [9:0] ar_idx;
lsip_rd_t next_rd;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

// two stages; pads are asynchronous to the bus clock
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        pin_meta <= 32'h0000_0000;
        pin_sync <= 32'h0000_0000;
    end else if (ce_in) begin
        pin_meta <= {g4_pin_in, g3_pin_in, g2_pin_in, g1_pin_in};
        pin_sync <= pin_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write path

// address and data may arrive in either order; one write in flight
assign s_axi_awready_out = ce_in & ~aw_full & ~bvalid;
assign s_axi_wready_out = ce_in & ~w_full & ~bvalid;
assign wr_fire = ce_in & aw_full & w_full & ~bvalid;
assign s_axi_bvalid_out = bvalid;
assign s_axi_bresp_out = bresp;

// capture write address
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        aw_full <= 1'b0;
        aw_idx <= 10'h000;
    end else if (ce_in) begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_full <= 1'b1;
            aw_idx <= s_axi_awaddr_in[11:2];
        end else if (wr_fire) begin
            aw_full <= 1'b0;
        end
    end
end

// capture write data; only the low lane holds register bits
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        w_full <= 1'b0;
        w_byte <= 8'h00;
        w_lane <= 1'b0;
    end else if (ce_in) begin
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_full <= 1'b1;
            w_byte <= s_axi_wdata_in[7:0];
            w_lane <= s_axi_wstrb_in[0];
        end else if (wr_fire) begin
            w_full <= 1'b0;
        end
    end
end

// decode: read-only data registers accept writes silently
always_comb begin
    unique case (aw_idx)
        `LSIP_IDX_G1_DATA, `LSIP_IDX_G2_DATA,
        `LSIP_IDX_G3_DATA, `LSIP_IDX_G4_DATA,
        `LSIP_IDX_G1_DIR, `LSIP_IDX_G2_DIR,
        `LSIP_IDX_G3_DIR, `LSIP_IDX_G4_DIR,
        `LSIP_IDX_SEG_EN: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
    endcase
end

// write response
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        bvalid <= 1'b0;
        bresp <= `LSIP_RESP_OKAY;
    end else if (ce_in) begin
        if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `LSIP_RESP_OKAY : `LSIP_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid <= 1'b0;
        end
    end
end

// register writes; a clear strobe on lane 0 leaves the byte alone
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        group_one_pin_data <= `LSIP_RST_LATCH;
        group_one_direction <= `LSIP_RST_DIR;
        group_two_direction <= `LSIP_RST_DIR;
        group_three_direction <= `LSIP_RST_DIR;
        group_four_direction <= `LSIP_RST_DIR;
        segment_enable_select <= `LSIP_RST_SEG_EN;
    end else if (wr_fire && w_lane) begin
        unique case (aw_idx)
            `LSIP_IDX_G1_DATA: group_one_pin_data <= w_byte;
            `LSIP_IDX_G1_DIR: group_one_direction <= w_byte;
            `LSIP_IDX_G2_DIR: group_two_direction <= w_byte;
            `LSIP_IDX_G3_DIR: group_three_direction <= w_byte;
            `LSIP_IDX_G4_DIR: group_four_direction <= w_byte;
            `LSIP_IDX_SEG_EN: segment_enable_select <= w_byte;
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read path

assign s_axi_arready_out = ce_in & ~rvalid;
assign s_axi_rvalid_out = rvalid;
assign s_axi_rdata_out = rd_hold.data;
assign s_axi_rresp_out = rd_hold.resp;
assign ar_idx = s_axi_araddr_in[11:2];

// data registers return pin levels, not the latch
always_comb begin
    next_rd = '{data: 32'h0000_0000, resp: `LSIP_RESP_OKAY};
    unique case (ar_idx)
        `LSIP_IDX_G1_DATA: next_rd.data[7:0] = pin_sync[7:0];
        `LSIP_IDX_G2_DATA: next_rd.data[7:0] = pin_sync[15:8];
        `LSIP_IDX_G3_DATA: next_rd.data[7:0] = pin_sync[23:16];
        `LSIP_IDX_G4_DATA: next_rd.data[7:0] = pin_sync[31:24];
        `LSIP_IDX_G1_DIR: next_rd.data[7:0] = group_one_direction;
        `LSIP_IDX_G2_DIR: next_rd.data[7:0] = group_two_direction;
        `LSIP_IDX_G3_DIR: next_rd.data[7:0] = group_three_direction;
        `LSIP_IDX_G4_DIR: next_rd.data[7:0] = group_four_direction;
        `LSIP_IDX_SEG_EN: next_rd.data[7:0] = segment_enable_select;
        default: next_rd.resp = `LSIP_RESP_SLVERR;
    endcase
end

// read answer held until taken
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        rvalid <= 1'b0;
        rd_hold <= '{data: 32'h0000_0000, resp: `LSIP_RESP_OKAY};
    end else if (ce_in) begin
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid <= 1'b1;
            rd_hold <= next_rd;
        end else if (s_axi_rready_in) begin
            rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// ownership of each pin by the lcd driver

// each enable bit fans out to a fixed subset
assign g1_lcd_own = {{3{segment_enable_select[`LSIP_SE_G1_HI]}},
                     {5{segment_enable_select[`LSIP_SE_G1_LO]}}};
assign g2_lcd_own = {segment_enable_select[`LSIP_SE_G],
                     {3{segment_enable_select[`LSIP_SE_C]}},
                     {4{segment_enable_select[`LSIP_SE_B]}}};
assign g3_lcd_own = {{4{segment_enable_select[`LSIP_SE_E]}},
                     {4{segment_enable_select[`LSIP_SE_D]}}};
assign g4_lcd_own = {segment_enable_select[`LSIP_SE_G],
                     {7{segment_enable_select[`LSIP_SE_F]}}};

// bit 7 pads of groups two and four are absent on the small package
assign large_mask = {LARGE_PKG, 7'h7f};

// upper pins of group one pick common or segment
assign g1_lcd_val[4:0] = lcd_seg_in[4:0];
assign g1_lcd_val[5] = lcd_com_sel_in[0] ? lcd_com_in[3] : lcd_seg_in[29];
assign g1_lcd_val[6] = lcd_com_sel_in[1] ? lcd_com_in[2] : lcd_seg_in[30];
assign g1_lcd_val[7] = lcd_com_sel_in[2] ? lcd_com_in[1] : lcd_seg_in[31];

////////////////////////////////////////////////////////////////////////////////
// pad drive

// group one: lcd wins over the direction bits; upper three never digital out
always_comb begin
    next_g1.enable = g1_lcd_own
                   | (~g1_lcd_own & ~group_one_direction & 8'h1f);
    next_g1.level = (g1_lcd_own & g1_lcd_val)
                  | (~g1_lcd_own & group_one_pin_data & 8'h1f);
end

// groups two to four drive only for the lcd
always_comb begin
    next_g2.enable = g2_lcd_own & large_mask;
    next_g2.level = {lcd_seg_in[27], lcd_seg_in[11:5]} & next_g2.enable;
    next_g3.enable = g3_lcd_own;
    next_g3.level = lcd_seg_in[19:12] & g3_lcd_own;
    next_g4.enable = g4_lcd_own & large_mask;
    next_g4.level = {lcd_seg_in[28], lcd_seg_in[26:20]} & next_g4.enable;
end

// registered pads so no glitch reaches a pin
always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
        g1_drv <= '{level: 8'h00, enable: 8'h00};
        g2_drv <= '{level: 8'h00, enable: 8'h00};
        g3_drv <= '{level: 8'h00, enable: 8'h00};
        g4_drv <= '{level: 8'h00, enable: 8'h00};
    end else if (ce_in) begin
        g1_drv <= next_g1;
        g2_drv <= next_g2;
        g3_drv <= next_g3;
        g4_drv <= next_g4;
    end
end

assign g1_pin_out = g1_drv.level;
assign g1_pin_oe_out = g1_drv.enable;
assign g2_pin_out = g2_drv.level;
assign g2_pin_oe_out = g2_drv.enable;
assign g3_pin_out = g3_drv.level;
assign g3_pin_oe_out = g3_drv.enable;
assign g4_pin_out = g4_drv.level;
assign g4_pin_oe_out = g4_drv.enable;

endmodule : lsip_top

`default_nettype wire

// [tb/lsip_pads.sv]
`timescale 1ns/1ps
`default_nettype none
module lsip_pads (
    // clock and outside levels
    input wire logic clk_sys_in,
    input wire logic [31:0] ext_lvl,
    // pad drive from the block
    input wire logic [7:0] g1_pin_out,
    input wire logic [7:0] g1_pin_oe_out,
    input wire logic [7:0] g2_pin_out,
    input wire logic [7:0] g2_pin_oe_out,
    input wire logic [7:0] g3_pin_out,
    input wire logic [7:0] g3_pin_oe_out,
    input wire logic [7:0] g4_pin_out,
    input wire logic [7:0] g4_pin_oe_out,
    // pad levels and lcd sources
    output logic [7:0] g1_pin_in,
    output logic [7:0] g2_pin_in,
    output logic [7:0] g3_pin_in,
    output logic [7:0] g4_pin_in,
    output logic [31:0] lcd_seg_in,
    output logic [3:1] lcd_com_in,
    output logic [2:0] lcd_com_sel_in
);
logic [7:0] cnt = 8'h00;
//////////////////////////////////////////////////////////////////////////////
// wire level: block wins where it drives, else outside circuit
assign g1_pin_in = (g1_pin_out & g1_pin_oe_out) | (ext_lvl[7:0] & ~g1_pin_oe_out);
assign g2_pin_in = (g2_pin_out & g2_pin_oe_out) | (ext_lvl[15:8] & ~g2_pin_oe_out);
assign g3_pin_in = (g3_pin_out & g3_pin_oe_out) | (ext_lvl[23:16] & ~g3_pin_oe_out);
assign g4_pin_in = (g4_pin_out & g4_pin_oe_out) | (ext_lvl[31:24] & ~g4_pin_oe_out);
// segment and select lines change every cycle so a stale copy shows
always_ff @(posedge clk_sys_in) cnt <= cnt + 8'h01;
assign lcd_seg_in = {cnt, ~cnt, cnt ^ 8'h69, cnt + 8'h35};
assign lcd_com_in = cnt[6:4] ^ cnt[3:1];
assign lcd_com_sel_in = cnt[2:0];
endmodule : lsip_pads
`default_nettype wire

// [tb/lsip_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module lsip_properties (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // bus handshakes
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    // lcd sources
    input wire logic [31:0] lcd_seg_in,
    input wire logic [3:1] lcd_com_in,
    input wire logic [2:0] lcd_com_sel_in,
    // pads
    input wire logic [7:0] g1_pin_out,
    input wire logic [7:0] g1_pin_oe_out,
    input wire logic [7:0] g2_pin_out,
    input wire logic [7:0] g2_pin_oe_out,
    input wire logic [7:0] g3_pin_out,
    input wire logic [7:0] g3_pin_oe_out,
    input wire logic [7:0] g4_pin_out,
    input wire logic [7:0] g4_pin_oe_out
);
logic [31:0] seg_q;
logic [3:1] com_q;
logic [2:0] sel_q;
logic [7:5] hi_exp;
//////////////////////////////////////////////////////////////////////////////
// copy of lcd sources, lined up with the registered pads; frozen with them while ce is low
always_ff @(posedge clk_sys_in) begin
    if (ce_in) begin
        seg_q <= lcd_seg_in;
        com_q <= lcd_com_in;
        sel_q <= lcd_com_sel_in;
    end
end
// common replaces segment per select bit
assign hi_exp = {sel_q[2] ? com_q[1] : seg_q[31], sel_q[1] ? com_q[2] : seg_q[30], sel_q[0] ? com_q[3] : seg_q[29]};
//////////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!resetn_in);
property p_g1_hi_in; g1_pin_oe_out[7:5] inside {3'h0, 3'h7}; endproperty
a_g1_hi_in: assert property (p_g1_hi_in)
    else $error("upper group one pads enabled apart");
property p_g1_hi_map; |g1_pin_oe_out[7:5] |-> g1_pin_out[7:5] == hi_exp; endproperty
a_g1_hi_map: assert property (p_g1_hi_map)
    else $error("upper group one pads carry wrong lcd line");
property p_g2_map; ((g2_pin_out ^ {seg_q[27], seg_q[11:5]}) & g2_pin_oe_out) == 8'h00; endproperty
a_g2_map: assert property (p_g2_map)
    else $error("group two segment order wrong");
property p_g3_map; ((g3_pin_out ^ seg_q[19:12]) & g3_pin_oe_out) == 8'h00; endproperty
a_g3_map: assert property (p_g3_map)
    else $error("group three segment order wrong");
property p_g4_map; ((g4_pin_out ^ {seg_q[28], seg_q[26:20]}) & g4_pin_oe_out) == 8'h00; endproperty
a_g4_map: assert property (p_g4_map)
    else $error("group four segment order wrong");
// enables move in whole subsets only
property p_subsets;
    g2_pin_oe_out[3:0] inside {4'h0, 4'hf} && g2_pin_oe_out[6:4] inside {3'h0, 3'h7}
    && g3_pin_oe_out[3:0] inside {4'h0, 4'hf} && g3_pin_oe_out[7:4] inside {4'h0, 4'hf}
    && g4_pin_oe_out[6:0] inside {7'h00, 7'h7f} && g2_pin_oe_out[7] == g4_pin_oe_out[7];
endproperty
a_subsets: assert property (p_subsets)
    else $error("pad enables split a subset");
property p_rd_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped before taken");
property p_boot; $rose(resetn_in) |-> ##[1:2] (&g1_pin_oe_out && &g3_pin_oe_out && &g2_pin_oe_out[6:0]); endproperty
a_boot: assert property (p_boot)
    else $error("pads not handed to lcd after reset");
// a low enable must hold group one pads and bus answers where they stand
property p_freeze;
    !ce_in |=> $stable({g1_pin_out, g1_pin_oe_out, s_axi_bvalid_out, s_axi_rvalid_out});
endproperty
a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
c_freeze: cover property (!ce_in);
c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
c_g1_out: cover property (g1_pin_oe_out == 8'h1f);
endmodule : lsip_properties
`default_nettype wire

// [tb/tb_lsip_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lsip_regs.svh"
module tb_lsip_top;
logic clk_sys_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1;
logic [31:0] s_axi_awaddr_in = 32'h0000_0000, s_axi_wdata_in = 32'h0000_0000, s_axi_araddr_in = 32'h0000_0000;
logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
logic [3:0] s_axi_wstrb_in = 4'hf;
logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
logic [31:0] s_axi_rdata_out, lcd_seg_in, seg_q, ext_lvl = 32'h5a3c_c3aa;
logic [3:1] lcd_com_in;
logic [2:0] lcd_com_sel_in;
logic [7:0] g1_pin_in, g1_pin_out, g1_pin_oe_out, g2_pin_in, g2_pin_out, g2_pin_oe_out;
logic [7:0] g3_pin_in, g3_pin_out, g3_pin_oe_out, g4_pin_in, g4_pin_out, g4_pin_oe_out;
int mismatches = 0, cmp_count = 0;
lsip_top lsip_top_inst (.*);
lsip_pads lsip_pads_inst (.*);
// clock and a one-cycle copy of segment data
always #2 clk_sys_in = ~clk_sys_in;
always @(posedge clk_sys_in) seg_q <= lcd_seg_in;
//////////////////////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
        mismatches++;
        $display("unexpected %s: expected %h seen %h", n, e, s);
    end
endtask : chk
// bus cycles: bounded waits so a dead slave still ends in a mismatch
task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= {20'h0_0000, i, 2'b00};
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (int k = 0; k < 64; k++) begin
        @(posedge clk_sys_in);
        if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        if (s_axi_bvalid_out === 1'b1) break;
    end
    s_axi_bready_in <= 1'b0;
    chk("bresp", {s_axi_bvalid_out, s_axi_bresp_out}, {1'b1, er});
endtask : wr
task automatic rd(input logic [9:0] i, input logic [1:0] er, input logic [7:0] ed);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= {20'h0_0000, i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (int k = 0; k < 64; k++) begin
        @(posedge clk_sys_in);
        if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        if (s_axi_rvalid_out === 1'b1) break;
    end
    s_axi_rready_in <= 1'b0;
    chk("rresp", {s_axi_rvalid_out, s_axi_rresp_out}, {1'b1, er});
    if (er == 2'b00) chk("rdata", s_axi_rdata_out, {24'h00_0000, ed});
endtask : rd
// pads are registered: let a few edges pass, then look off the edge
task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    #1;
endtask : settle
//////////////////////////////////////////////////////////////////////////////
task automatic t_boot;
    settle();
    chk("oe", {g4_pin_oe_out, g3_pin_oe_out, g2_pin_oe_out, g1_pin_oe_out}, 32'hffff_ffff);
    rd(`LSIP_IDX_G1_DIR, 2'b00, 8'hff);
    rd(`LSIP_IDX_G2_DIR, 2'b00, 8'hff);
    rd(`LSIP_IDX_G3_DIR, 2'b00, 8'hff);
    rd(`LSIP_IDX_G4_DIR, 2'b00, 8'hff);
    rd(`LSIP_IDX_SEG_EN, 2'b00, 8'hff);
    rd(10'h1ff, `LSIP_RESP_SLVERR, 8'h00);
    wr(10'h1ff, 8'h00, `LSIP_RESP_SLVERR);
    $display("boot done");
endtask : t_boot
task automatic t_group_one;
    wr(`LSIP_IDX_SEG_EN, 8'h7e, 2'b00);
    wr(`LSIP_IDX_G1_DIR, 8'he0, 2'b00);
    wr(`LSIP_IDX_G1_DATA, 8'hf5, 2'b00);
    settle();
    chk("g1 oe", g1_pin_oe_out, 8'h1f);
    chk("g1 level", g1_pin_out[4:0], 5'h15);
    rd(`LSIP_IDX_G1_DATA, 2'b00, 8'hb5);
    wr(`LSIP_IDX_G1_DIR, 8'h00, 2'b00);
    settle();
    chk("g1 oe", g1_pin_oe_out, 8'h1f);
    wr(`LSIP_IDX_G1_DIR, 8'hff, 2'b00);
    settle();
    chk("g1 oe", g1_pin_oe_out, 8'h00);
    rd(`LSIP_IDX_G1_DATA, 2'b00, 8'haa);
    $display("group one done");
endtask : t_group_one
task automatic t_override;
    wr(`LSIP_IDX_G1_DIR, 8'h00, 2'b00);
    wr(`LSIP_IDX_SEG_EN, 8'h81, 2'b00);
    settle();
    chk("g1 oe", g1_pin_oe_out, 8'hff);
    chk("g1 seg", g1_pin_out[4:0], seg_q[4:0]);
    $display("override done");
endtask : t_override
// clock enable low: pads and bus stand still although the lcd lines move
task automatic t_freeze;
    logic [7:0] held;
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    settle();
    held = g1_pin_out;
    settle();
    chk("frozen g1 level", g1_pin_out, held);
    chk("frozen awready", s_axi_awready_out, 32'h0000_0000);
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    $display("freeze done");
endtask : t_freeze
task automatic t_inputs;
    wr(`LSIP_IDX_SEG_EN, 8'h00, 2'b00);
    wr(`LSIP_IDX_G2_DIR, 8'h00, 2'b00);
    wr(`LSIP_IDX_G3_DIR, 8'h00, 2'b00);
    wr(`LSIP_IDX_G4_DIR, 8'h00, 2'b00);
    wr(`LSIP_IDX_G2_DATA, 8'hff, 2'b00);
    settle();
    chk("g2-4 oe", {g4_pin_oe_out, g3_pin_oe_out, g2_pin_oe_out}, 24'h00_0000);
    rd(`LSIP_IDX_G2_DATA, 2'b00, 8'hc3);
    rd(`LSIP_IDX_G3_DATA, 2'b00, 8'h3c);
    rd(`LSIP_IDX_G4_DATA, 2'b00, 8'h5a);
    $display("inputs done");
endtask : t_inputs
task automatic t_subsets;
    logic [31:0] tab [8] = '{32'h0000_001f, 32'h0000_0f00, 32'h0000_7000, 32'h000f_0000,
        32'h00f0_0000, 32'h7f00_0000, 32'h8000_8000, 32'h0000_00e0};
    wr(`LSIP_IDX_G1_DIR, 8'hff, 2'b00);
    for (int b = 0; b < 8; b++) begin
        wr(`LSIP_IDX_SEG_EN, 8'h01 << b, 2'b00);
        settle();
        chk("oe map", {g4_pin_oe_out, g3_pin_oe_out, g2_pin_oe_out, g1_pin_oe_out}, tab[b]);
    end
    // masked lane must leave the enables alone
    @(posedge clk_sys_in);
    s_axi_wstrb_in <= 4'h0;
    wr(`LSIP_IDX_SEG_EN, 8'hff, 2'b00);
    s_axi_wstrb_in <= 4'hf;
    rd(`LSIP_IDX_SEG_EN, 2'b00, 8'h80);
    $display("subsets done");
endtask : t_subsets
//////////////////////////////////////////////////////////////////////////////
task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask : close_out
// main sequence
initial begin
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_boot();
    t_group_one();
    t_override();
    t_freeze();
    t_inputs();
    t_subsets();
    close_out();
end
// watchdog: the tests need well under a few thousand cycles
initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    close_out();
end
endmodule : tb_lsip_top
bind lsip_top lsip_properties lsip_properties_inst (.*);
`default_nettype wire
